// file: bench/tmc_cpu_model.sv
module tmc_cpu_model (
  input  wire logic [7:0] sfr_rdata_i,
  input  wire logic       sys_clk_i,
  output logic [7:0]      sfr_addr_o,
  output logic            sfr_wr_o,
  output logic [7:0]      sfr_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;

  initial begin
    sfr_addr_o  = 8'h00;
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = 8'h00;
  end

  // Driven at the falling edge, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_addr_o  = a;
    sfr_wdata_o = d;
    sfr_wr_o    = 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_o    = 1'b0;
    sfr_wdata_o = ~d;
  endtask

  // Read data lags the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_addr_o = a;
    @(negedge sys_clk_i);
    d = sfr_rdata_i;
  endtask

  // Software owns flag clearing; keep only control bits
  task automatic clr3(input logic [7:0] ctl);
    wr(ADDR_T3CTL, ctl & 8'h3f);
  endtask
endmodule

// file: bench/tmc_timer_block_tb.sv
module tmc_timer_block_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;

  logic        sys_clk_i;
  logic        rst_i;
  logic        wr;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  v;
  logic [15:0] w;
  logic [15:0] w2;
  logic        pin_a;
  logic        pin_b;
  logic        p0;
  logic        p1;
  logic        p3;
  logic        trg;
  logic        ien;
  logic        t0_irq;
  logic        t1_irq;
  logic        t3_irq;
  tmc_baud_s   baud;
  int          n_errors;
  int          checks_done;
  int          nb1;
  int          nb2;

  tmc_timer_block tmc_timer_block_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b),
    .t0_count_pin_i(p0), .t1_count_pin_i(p1), .t3_count_pin_i(p3),
    .t3_trigger_input_i(trg), .t3_int_enable_i(ien),
    .t0_irq_o(t0_irq), .t1_irq_o(t1_irq), .t3_irq_o(t3_irq),
    .baud_o(baud)
  );

  tmc_cpu_model cpu (
    .sfr_rdata_i(rdata), .sys_clk_i(sys_clk_i), .sfr_addr_o(addr),
    .sfr_wr_o(wr), .sfr_wdata_o(wdata)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  always @(negedge sys_clk_i) begin
    nb1 += int'(baud.port1_rx === 1'b1);
    nb2 += int'(baud.port2_rx === 1'b1);
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Range compare; an unknown never lands inside the range
  task automatic chk(input logic [15:0] g, input logic [15:0] lo,
                     input logic [15:0] hi);
    checks_done++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask

  // Stop first so a tick cannot carry between byte writes
  task automatic t3_set(input logic [7:0] c, input logic [15:0] n,
                        input logic [15:0] r);
    cpu.wr(ADDR_T3CTL, 8'h00);
    cpu.wr(ADDR_T3L, n[7:0]);
    cpu.wr(ADDR_T3H, n[15:8]);
    cpu.wr(ADDR_CAPL, r[7:0]);
    cpu.wr(ADDR_CAPH, r[15:8]);
    cpu.wr(ADDR_T3CTL, c);
  endtask

  task automatic rd16(output logic [15:0] q);
    cpu.rd(ADDR_T3L, q[7:0]);
    cpu.rd(ADDR_T3H, q[15:8]);
  endtask

  task automatic t_basic;
    cpu.wr(ADDR_TMOD, 8'h09);
    cpu.wr(ADDR_TCON, 8'h10);
    cyc(40);
    cpu.rd(ADDR_T0L, v);
    chk(v, 8'h00, 8'h00);
    pin_a = 1'b1;
    cyc(40);
    cpu.rd(ADDR_T0L, v);
    chk(v, 8'h02, 8'h04);
    cpu.wr(ADDR_TCON, 8'h00);
    cpu.wr(ADDR_TMOD, 8'h02);
    cpu.wr(ADDR_T0H, 8'hf0);
    cpu.wr(ADDR_T0L, 8'hfe);
    cpu.wr(ADDR_TCON, 8'h10);
    cyc(30);
    chk(t0_irq, 1, 1);
    cpu.rd(ADDR_T0L, v);
    chk(v, 8'hf0, 8'hf1);
    cpu.rd(ADDR_T0H, v);
    chk(v, 8'hf0, 8'hf0);
    $display("done: basic timer modes");
  endtask

  task automatic t_split;
    cpu.wr(ADDR_TCON, 8'h00);
    cpu.wr(ADDR_TMOD, 8'h23);
    cpu.wr(ADDR_T1H, 8'hff);
    // Low byte at the reload value, so every tick overflows
    cpu.wr(ADDR_T1L, 8'hff);
    cpu.wr(ADDR_T0H, 8'hf0);
    cpu.wr(ADDR_T0L, 8'h00);
    cpu.wr(ADDR_TCON, 8'h40);
    nb1 = 0;
    cyc(60);
    chk(t1_irq, 0, 0);
    chk(nb1, 4, 6);
    cyc(160);
    chk(t1_irq, 1, 1);
    cpu.rd(ADDR_T0L, v);
    chk(v, 8'h00, 8'h00);
    cpu.wr(ADDR_TMOD, 8'h33);
    cpu.rd(ADDR_T1L, v);
    nb1 = 0;
    cyc(40);
    chk(nb1, 0, 0);
    cpu.rd(ADDR_T1L, w[7:0]);
    chk(w[7:0], v, v);
    cpu.wr(ADDR_TMOD, 8'h23);
    nb1 = 0;
    cyc(40);
    chk(nb1, 2, 4);
    cpu.wr(ADDR_TCON, 8'h00);
    $display("done: split mode");
  endtask

  task automatic t_capture;
    t3_set(8'h05, 16'hfffe, 16'h0000);
    cyc(30);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h85, 8'h85);
    chk(t3_irq, 1, 1);
    cyc(30);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h85, 8'h85);
    cpu.clr3(8'h01);
    rd16(w);
    cyc(40);
    rd16(w2);
    chk(w2, w, w);
    chk(t3_irq, 0, 0);
    trg = 1'b1;
    t3_set(8'h0d, 16'h1234, 16'h0000);
    cyc(30);
    trg = 1'b0;
    cyc(30);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h4d, 8'h4d);
    chk(t3_irq, 1, 1);
    ien = 1'b0;
    cyc(1);
    chk(t3_irq, 0, 0);
    ien = 1'b1;
    cpu.rd(ADDR_CAPH, v);
    chk(v, 8'h12, 8'h12);
    cpu.rd(ADDR_CAPL, v);
    chk(v, 8'h35, 8'h3c);
    $display("done: capture");
  endtask

  task automatic t_reload;
    t3_set(8'h04, 16'hfffe, 16'habcd);
    cyc(30);
    rd16(w);
    chk(w, 16'habcd, 16'habcf);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h84, 8'h84);
    trg = 1'b1;
    t3_set(8'h0c, 16'h0010, 16'habcd);
    cyc(30);
    trg = 1'b0;
    cyc(30);
    rd16(w);
    chk(w, 16'habcd, 16'habd3);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h4c, 8'h4c);
    trg = 1'b1;
    t3_set(8'h04, 16'h0010, 16'habcd);
    cyc(30);
    trg = 1'b0;
    cyc(30);
    rd16(w);
    chk(w, 16'h0014, 16'h0017);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h04, 8'h04);
    cpu.wr(ADDR_T3MODE, 8'h01);
    t3_set(8'h04, 16'h0010, 16'h0000);
    cyc(40);
    rd16(w);
    chk(w, 16'h000b, 16'h000f);
    cpu.wr(ADDR_T3MODE, 8'h00);
    $display("done: reload");
  endtask

  task automatic t_baud;
    t3_set(8'h25, 16'hfffe, 16'hfffe);
    nb1 = 0;
    cyc(60);
    chk(nb1, 1, 3);
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h25, 8'h25);
    rd16(w);
    chk(w, 16'hfffe, 16'hffff);
    cpu.wr(ADDR_T3CTL, 8'h04);
    cpu.wr(ADDR_POWER_CONTROL_REG, 8'h20);
    nb2 = 0;
    cyc(60);
    chk(nb2, 1, 3);
    cpu.wr(ADDR_POWER_CONTROL_REG, 8'h00);
    p3 = 1'b1;
    t3_set(8'h06, 16'h0000, 16'h0000);
    cyc(30);
    repeat (3) begin
      p3 = 1'b0;
      cyc(24);
      p3 = 1'b1;
      cyc(24);
    end
    rd16(w);
    chk(w, 16'h0003, 16'h0003);
    $display("done: baud and source");
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole sequence needs about 1300 clocks
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    end_sim();
  end

  initial begin
    rst_i = 1'b1;
    pin_a = 1'b0;
    pin_b = 1'b1;
    p0 = 1'b1;
    p1 = 1'b1;
    p3 = 1'b1;
    trg = 1'b1;
    ien = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    cpu.rd(ADDR_T3CTL, v);
    chk(v, 8'h00, 8'h00);
    t_basic();
    t_split();
    t_capture();
    t_reload();
    t_baud();
    end_sim();
  end
endmodule

// file: hw/tmc_fall_edge.sv
module tmc_fall_edge (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  input  wire logic pin_i,
  output logic      fall_o
);
  import tmc_pkg::*;

  // Sampled once per machine cycle, so counting tops out at fosc/24
  logic last;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last <= 1'b1;
    end else if (tick_i) begin
      last <= pin_i;
    end
  end

  assign fall_o = tick_i & last & ~pin_i;
endmodule

// file: hw/tmc_pkg.sv
package tmc_pkg;

  // Machine cycle is one twelfth of the oscillator clock
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned MACHINE_DIV = 12;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_TCON   = 8'h00;
  localparam logic [7:0] ADDR_TMOD   = 8'h01;
  localparam logic [7:0] ADDR_T0L    = 8'h02;
  localparam logic [7:0] ADDR_T0H    = 8'h03;
  localparam logic [7:0] ADDR_T1L    = 8'h04;
  localparam logic [7:0] ADDR_T1H    = 8'h05;
  localparam logic [7:0] ADDR_T3CTL  = 8'h06;
  localparam logic [7:0] ADDR_T3MODE = 8'h07;
  localparam logic [7:0] ADDR_POWER_CONTROL_REG   = 8'h08;
  localparam logic [7:0] ADDR_T3L    = 8'h09;
  localparam logic [7:0] ADDR_T3H    = 8'h0a;
  localparam logic [7:0] ADDR_CAPL   = 8'h0b;
  localparam logic [7:0] ADDR_CAPH   = 8'h0c;

  // Field positions
  localparam int unsigned DCEN_BIT    = 0;
  localparam int unsigned P2_RX_BIT   = 5;
  localparam int unsigned P2_TX_BIT   = 4;

  // Reset values
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;

  typedef enum logic [1:0] {
    MODE_13      = 2'b00,
    MODE_16      = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT   = 2'b11
  } tmc_mode_e;

  typedef struct packed {
    logic      gate;
    logic      counter_mode;
    tmc_mode_e mode;
  } tmc_tmod_half_s;

  typedef struct packed {
    tmc_tmod_half_s t1;
    tmc_tmod_half_s t0;
  } tmc_tmod_s;

  typedef struct packed {
    logic       t1_overflow_flag;
    logic       t1_run_bit;
    logic       t0_overflow_flag;
    logic       t0_run_bit;
    logic [3:0] ext_irq_ctl;
  } tmc_tcon_s;

  typedef struct packed {
    logic t3_overflow_flag;
    logic t3_trigger_flag;
    logic rx_baud_select;
    logic tx_baud_select;
    logic t3_trigger_enable;
    logic t3_run_bit;
    logic t3_source_select;
    logic capture_or_reload_select;
  } tmc_t3ctl_s;

  typedef struct packed {
    logic port1_rx;
    logic port1_tx;
    logic port2_rx;
    logic port2_tx;
  } tmc_baud_s;

endpackage

// file: hw/tmc_tick_gen.sv
module tmc_tick_gen (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  import tmc_pkg::*;

  localparam logic [3:0] LAST = 4'(MACHINE_DIV - 1);

  logic [3:0] phase;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= 4'h0;
    end else if (phase == LAST) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  assign tick_o = (phase == LAST);
endmodule

// file: hw/tmc_timer_block.sv
// Functional notes
// - Mode 2: low byte reloads from high
// - Second timer mode 3 freezes count
// - First timer mode 3: low byte own controls
// - Split high byte: machine cycles, second's bits
// - Second timer still feeds baud when split
// - Third timer source: cycles or pin edges
// - Capture mode: 16-bit count, overflow flag
// - Trigger fall copies count to capture
// - Up overflow reloads count from capture bytes; down-count underflow loads ffff
// - Trigger fall also reloads when enabled
// - Baud select forces auto-reload
// - Baud use suppresses overflow flag
// - Flags set by hardware, cleared by software
// - Trigger flag requests interrupt like overflow
// - Port one baud from third or second
// - Port two selects in power register
// - Trigger acts only enabled; in baud it only sets the flag
// - Run bit starts and holds third timer
// - Basic timer runs with run and gate
module tmc_timer_block (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_i,
  input  wire logic [7:0]    sfr_addr_i,
  input  wire logic          sfr_wr_i,
  input  wire logic [7:0]    sfr_wdata_i,
  output logic [7:0]         sfr_rdata_o,
  input  wire logic          ext_irq_pin_a_i,
  input  wire logic          ext_irq_pin_b_i,
  input  wire logic          t0_count_pin_i,
  input  wire logic          t1_count_pin_i,
  input  wire logic          t3_count_pin_i,
  input  wire logic          t3_trigger_input_i,
  input  wire logic          t3_int_enable_i,
  output logic               t0_irq_o,
  output logic               t1_irq_o,
  output logic               t3_irq_o,
  output tmc_pkg::tmc_baud_s baud_o
);
  import tmc_pkg::*;

  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  tmc_tcon_s  tcon;
  tmc_tmod_s  tmod;
  tmc_t3ctl_s t3ctl;
  logic [7:0] t0_low_byte;
  logic [7:0] t0_high_byte;
  logic [7:0] t1_low_byte;
  logic [7:0] t1_high_byte;
  logic [7:0] t3_mode_reg;
  logic [7:0] power_control_reg;
  logic [15:0] t3_cnt;
  logic [15:0] t3_cap;

  logic tick;
  logic t0_fall;
  logic t1_fall;
  logic t3_fall;
  logic trig_fall;

  tmc_tick_gen u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_o    (tick)
  );

  tmc_fall_edge u_t0_pin (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .pin_i     (t0_count_pin_i),
    .fall_o    (t0_fall)
  );

  tmc_fall_edge u_t1_pin (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .pin_i     (t1_count_pin_i),
    .fall_o    (t1_fall)
  );

  tmc_fall_edge u_t3_pin (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .pin_i     (t3_count_pin_i),
    .fall_o    (t3_fall)
  );

  tmc_fall_edge u_trig_pin (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_i    (tick),
    .pin_i     (t3_trigger_input_i),
    .fall_o    (trig_fall)
  );

  // Basic timers
  logic split;
  logic t0_en;
  logic t1_en;
  logic th0_en;
  logic t0_ovf;
  logic t1_ovf;
  logic th0_ovf;
  logic t1_flag_set;
  logic [7:0] next_t0_low;
  logic [7:0] next_t0_high;
  logic [7:0] next_t1_low;
  logic [7:0] next_t1_high;

  assign split  = (tmod.t0.mode == MODE_SPLIT);
  assign t0_en  = tcon.t0_run_bit & (~tmod.t0.gate | ext_irq_pin_a_i) &
                  (tmod.t0.counter_mode ? t0_fall : tick);
  assign t1_en  = tcon.t1_run_bit & (~tmod.t1.gate | ext_irq_pin_b_i) &
                  (tmod.t1.counter_mode ? t1_fall : tick) &
                  (tmod.t1.mode != MODE_SPLIT);
  assign th0_en = split & tcon.t1_run_bit & tick;
  // Split high byte owns the second timer's flag
  assign t1_flag_set = split ? th0_ovf : t1_ovf;

  // Modes 0 and 1 both run the full 16 bits here
  always_comb begin
    next_t0_low  = t0_low_byte;
    next_t0_high = t0_high_byte;
    t0_ovf       = 1'b0;
    th0_ovf      = 1'b0;
    case (tmod.t0.mode)
      MODE_RELOAD8: begin
        if (t0_en) begin
          if (t0_low_byte == 8'hff) begin
            next_t0_low = t0_high_byte;
            t0_ovf      = 1'b1;
          end else begin
            next_t0_low = t0_low_byte + 8'h01;
          end
        end
      end
      MODE_SPLIT: begin
        if (t0_en) begin
          {t0_ovf, next_t0_low} = {1'b0, t0_low_byte} + 9'h001;
        end
        if (th0_en) begin
          {th0_ovf, next_t0_high} = {1'b0, t0_high_byte} + 9'h001;
        end
      end
      default: begin
        if (t0_en) begin
          {t0_ovf, next_t0_high, next_t0_low} =
            {1'b0, t0_high_byte, t0_low_byte} + 17'h00001;
        end
      end
    endcase
  end

  always_comb begin
    next_t1_low  = t1_low_byte;
    next_t1_high = t1_high_byte;
    t1_ovf       = 1'b0;
    if (t1_en) begin
      if (tmod.t1.mode == MODE_RELOAD8) begin
        if (t1_low_byte == 8'hff) begin
          next_t1_low = t1_high_byte;
          t1_ovf      = 1'b1;
        end else begin
          next_t1_low = t1_low_byte + 8'h01;
        end
      end else begin
        {t1_ovf, next_t1_high, next_t1_low} =
          {1'b0, t1_high_byte, t1_low_byte} + 17'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t0_low_byte  <= RESET_BYTE;
      t0_high_byte <= RESET_BYTE;
      t1_low_byte  <= RESET_BYTE;
      t1_high_byte <= RESET_BYTE;
    end else begin
      t0_low_byte  <= wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T0L) ?
                      sfr_wdata_i : next_t0_low;
      t0_high_byte <= wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T0H) ?
                      sfr_wdata_i : next_t0_high;
      t1_low_byte  <= wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T1L) ?
                      sfr_wdata_i : next_t1_low;
      t1_high_byte <= wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T1H) ?
                      sfr_wdata_i : next_t1_high;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tcon <= tmc_tcon_s'(RESET_BYTE);
      tmod <= tmc_tmod_s'(RESET_BYTE);
    end else begin
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_TMOD)) begin
        tmod <= tmc_tmod_s'(sfr_wdata_i);
      end
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_TCON)) begin
        tcon <= tmc_tcon_s'(sfr_wdata_i);
      end
      if (t0_ovf) begin
        tcon.t0_overflow_flag <= 1'b1;
      end
      if (t1_flag_set) begin
        tcon.t1_overflow_flag <= 1'b1;
      end
    end
  end

  // Third timer
  logic baud;
  logic reload_mode;
  logic down_mode;
  logic down;
  logic t3_en;
  logic up_ovf;
  logic dn_ovf;
  logic t3_ovf;
  logic trig_act;
  logic trig_flag_set;
  logic [15:0] next_t3_cnt;

  assign baud = t3ctl.rx_baud_select | t3ctl.tx_baud_select |
                power_control_reg[P2_RX_BIT] |
                power_control_reg[P2_TX_BIT];
  assign reload_mode = baud | ~t3ctl.capture_or_reload_select;
  assign down_mode   = ~baud & ~t3ctl.capture_or_reload_select &
                       t3_mode_reg[DCEN_BIT];
  assign down  = down_mode & ~t3_trigger_input_i;
  assign t3_en = t3ctl.t3_run_bit &
                 (t3ctl.t3_source_select ? t3_fall : tick);
  assign up_ovf = t3_en & ~down & (t3_cnt == 16'hffff);
  assign dn_ovf = t3_en & down & (t3_cnt == t3_cap);
  assign t3_ovf = up_ovf | dn_ovf;
  // Trigger pin is the direction in down-count mode, never an event
  assign trig_act = t3ctl.t3_trigger_enable & trig_fall & ~baud &
                    ~down_mode;
  assign trig_flag_set = t3ctl.t3_trigger_enable & trig_fall &
                         ~down_mode;

  always_comb begin
    next_t3_cnt = t3_cnt;
    if (trig_act && reload_mode) begin
      next_t3_cnt = t3_cap;
    end else if (up_ovf) begin
      next_t3_cnt = reload_mode ? t3_cap : 16'h0000;
    end else if (dn_ovf) begin
      next_t3_cnt = 16'hffff;
    end else if (t3_en) begin
      next_t3_cnt = down ? t3_cnt - 16'h0001 : t3_cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t3_cnt <= RESET_WORD;
    end else if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T3L)) begin
      t3_cnt <= {t3_cnt[15:8], sfr_wdata_i};
    end else if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T3H)) begin
      t3_cnt <= {sfr_wdata_i, t3_cnt[7:0]};
    end else begin
      t3_cnt <= next_t3_cnt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t3_cap <= RESET_WORD;
    end else if (trig_act && !reload_mode) begin
      t3_cap <= t3_cnt;
    end else if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_CAPL)) begin
      t3_cap <= {t3_cap[15:8], sfr_wdata_i};
    end else if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_CAPH)) begin
      t3_cap <= {sfr_wdata_i, t3_cap[7:0]};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t3ctl             <= tmc_t3ctl_s'(RESET_BYTE);
      t3_mode_reg       <= RESET_BYTE;
      power_control_reg <= RESET_BYTE;
    end else begin
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T3CTL)) begin
        t3ctl <= tmc_t3ctl_s'(sfr_wdata_i);
      end
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_T3MODE)) begin
        t3_mode_reg <= sfr_wdata_i;
      end
      if (wr_hit(sfr_wr_i, sfr_addr_i, ADDR_POWER_CONTROL_REG)) begin
        power_control_reg <= sfr_wdata_i;
      end
      if (t3_ovf && !baud) begin
        t3ctl.t3_overflow_flag <= 1'b1;
      end
      if (trig_flag_set) begin
        t3ctl.t3_trigger_flag <= 1'b1;
      end
    end
  end

  // Baud pulses, registered so the serial ports see clean strobes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_o <= '0;
    end else begin
      baud_o.port1_rx <= t3ctl.rx_baud_select ? t3_ovf : t1_ovf;
      baud_o.port1_tx <= t3ctl.tx_baud_select ? t3_ovf : t1_ovf;
      baud_o.port2_rx <= power_control_reg[P2_RX_BIT] ?
                         t3_ovf : t1_ovf;
      baud_o.port2_tx <= power_control_reg[P2_TX_BIT] ?
                         t3_ovf : t1_ovf;
    end
  end

  assign t0_irq_o = tcon.t0_overflow_flag;
  assign t1_irq_o = tcon.t1_overflow_flag;
  assign t3_irq_o = t3_int_enable_i &
                    (t3ctl.t3_overflow_flag | t3ctl.t3_trigger_flag);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_rdata_o <= RESET_BYTE;
    end else if (sfr_addr_i == ADDR_TCON) begin
      sfr_rdata_o <= tcon;
    end else if (sfr_addr_i == ADDR_TMOD) begin
      sfr_rdata_o <= tmod;
    end else if (sfr_addr_i == ADDR_T0L) begin
      sfr_rdata_o <= t0_low_byte;
    end else if (sfr_addr_i == ADDR_T0H) begin
      sfr_rdata_o <= t0_high_byte;
    end else if (sfr_addr_i == ADDR_T1L) begin
      sfr_rdata_o <= t1_low_byte;
    end else if (sfr_addr_i == ADDR_T1H) begin
      sfr_rdata_o <= t1_high_byte;
    end else if (sfr_addr_i == ADDR_T3CTL) begin
      sfr_rdata_o <= t3ctl;
    end else if (sfr_addr_i == ADDR_T3MODE) begin
      sfr_rdata_o <= t3_mode_reg;
    end else if (sfr_addr_i == ADDR_POWER_CONTROL_REG) begin
      sfr_rdata_o <= power_control_reg;
    end else if (sfr_addr_i == ADDR_T3L) begin
      sfr_rdata_o <= t3_cnt[7:0];
    end else if (sfr_addr_i == ADDR_T3H) begin
      sfr_rdata_o <= t3_cnt[15:8];
    end else if (sfr_addr_i == ADDR_CAPL) begin
      sfr_rdata_o <= t3_cap[7:0];
    end else if (sfr_addr_i == ADDR_CAPH) begin
      sfr_rdata_o <= t3_cap[15:8];
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  reload8_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tmod.t0.mode == MODE_RELOAD8 && t0_en && t0_low_byte == 8'hff &&
     !sfr_wr_i) |=> (t0_low_byte == $past(t0_high_byte) &&
                     tcon.t0_overflow_flag))
    else $error("mode 2 reload failed");

  t1_freeze_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (tmod.t1.mode == MODE_SPLIT && !sfr_wr_i) |=>
      $stable({t1_high_byte, t1_low_byte}))
    else $error("second timer moved in mode 3");

  split_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (split && tcon.t1_run_bit && tick && t0_high_byte == 8'hff &&
     !sfr_wr_i) |=> (tcon.t1_overflow_flag && t0_high_byte == 8'h00))
    else $error("split high byte overflow lost");

  t3_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!t3ctl.t3_run_bit && !trig_act && !sfr_wr_i) |=> $stable(t3_cnt))
    else $error("third timer moved while stopped");

  capture_copy_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (trig_act && !reload_mode) |=>
      (t3_cap == $past(t3_cnt) && t3ctl.t3_trigger_flag))
    else $error("capture did not copy count");

  ovf_reload_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (up_ovf && reload_mode && !trig_act && !sfr_wr_i) |=>
      (t3_cnt == $past(t3_cap)))
    else $error("overflow reload wrong");

  baud_noflag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (baud && !t3ctl.t3_overflow_flag && !sfr_wr_i) |=>
      !t3ctl.t3_overflow_flag)
    else $error("overflow flag set in baud use");

  trig_ignore_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!t3ctl.t3_trigger_enable && !t3ctl.t3_trigger_flag && !sfr_wr_i)
      |=> !t3ctl.t3_trigger_flag)
    else $error("trigger flag set while disabled");

  route_port1_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (t3ctl.rx_baud_select && t3_ovf) |=> ##0 baud_o.port1_rx ##1
      !baud_o.port1_rx || $past(t3_ovf))
    else $error("port one receive clock not routed");

  t3_irq_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (t3_int_enable_i && t3ctl.t3_trigger_flag) |-> t3_irq_o)
    else $error("trigger flag did not request interrupt");
endmodule
